// ### verilog/spu_consts.vh
// Constants for the serial port block: register map, control fields, modes, timing
`ifndef SPU_CONSTS_VH
`define SPU_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define SPU_IDX_CTRL_HIGH   8'h00
`define SPU_IDX_CTRL_LOW    8'h01
`define SPU_IDX_BAUD        8'h03
`define SPU_IDX_DATA        8'hf0
`define SPU_ADDR_W          10
// High control fields
`define SPU_H_MODE_HI       7
`define SPU_H_MODE_LO       6
`define SPU_H_MPFILT        5
`define SPU_H_RXEN          4
`define SPU_H_TX9           3
`define SPU_H_RX9           2
`define SPU_H_RXIE          1
`define SPU_H_RXPEND        0
// Low control fields
`define SPU_L_PARGEN        7
`define SPU_L_CLK_HI        3
`define SPU_L_CLK_LO        2
`define SPU_L_TXIE          1
`define SPU_L_TXPEND        0
// Modes
`define SPU_MODE_SYNC       2'b00
`define SPU_MODE_ASYNC8     2'b01
`define SPU_MODE_ASYNC9F    2'b10
`define SPU_MODE_ASYNC9V    2'b11
// Oversampling
`define SPU_OVS_LAST        4'hf
`define SPU_OVS_MID         4'h7
`define SPU_CTRL_RESET      8'h00
`define SPU_IDLE_LINE       1'b1
// Bit counts: sync 8 bits; async 8 data + optional ninth + stop
`define SPU_SYNC_LAST       4'h7
`define SPU_D8_LAST         4'h8
`define SPU_D9_LAST         4'h9
`endif

// ### verilog/spu_serial_port.v
// Serial port with sync shift and 8/9-bit async modes, APB register access
// Operation
// - Sync mode sets receive pending after eighth bit shifted in.
// - 8-bit async sets receive pending at stop bit midpoint.
// - 9-bit async sets receive pending at ninth bit midpoint.
// - Pending flags stay set until software writes them clear.
// - Sync mode sets transmit pending after eighth bit shifted out.
// - Async modes set transmit pending as stop bit begins.
// - Sync bit rate is clock over 16 times divisor plus one.
// - Fixed 9-bit mode runs at clock over 16.
// - 8-bit and variable 9-bit run at clock over 16 times divisor plus one.
// - Sync mode: data on rx pin both ways, clock on tx pin, LSB first.
// - Mode bits 7:6 of high control pick sync, 8-bit, fixed 9-bit.
// - Sync receive runs when pending clear and receive enable set.
// - Receive interrupt request only while receive interrupt enable set.
// - Clock source select at low control bits 3:2.
// - Low control bit 7 makes hardware supply the parity bit.
// - 8-bit frame: start, eight data LSB first, stop.
// - Hardware inserts start and stop around the data byte.
// - Async receive starts on low start bit when receive enabled.
// - 9-bit frame: start, eight data, ninth bit, stop.
// - Ninth bit sent from control bit 3, received into bit 2.
// - A write to the data register starts a transmission.
// - Data writes load transmit buffer, reads return receive buffer.
// - In async modes next byte may arrive before read; unread byte is overwritten.
// - Mode bits 11 select variable-rate 9-bit async.
// - Filter bit blocks receive interrupt when ninth bit is zero.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "spu_consts.vh"
module spu_serial_port (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_pin_in,
  output reg         rx_pin_out,
  output reg         rx_pin_oe,
  output reg         tx_pin,
  output reg         rx_irq,
  output reg         tx_irq,
  output reg  [1:0]  clk_source_sel
);

  reg [7:0] ctrl_high;
  reg [7:0] ctrl_low;
  reg [7:0] baud_divisor;
  reg [7:0] rx_buffer;
  reg [7:0] tx_shift;
  reg       tx_ninth;
  reg [7:0] rx_shift;
  reg [7:0] baud_cnt;
  reg       rx_sync1;
  reg       rx_sync2;
  reg       rx_armed;

  localparam TX_IDLE  = 4'b0001;
  localparam TX_START = 4'b0010;
  localparam TX_DATA  = 4'b0100;
  localparam TX_STOP  = 4'b1000;
  localparam RX_IDLE  = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA  = 3'b100;

  reg [3:0] tx_state;
  reg [3:0] tx_ovs;
  reg [3:0] tx_bit;
  reg [2:0] rx_state;
  reg [3:0] rx_ovs;
  reg [3:0] rx_bit;

  function [9:0] reg_addr;
    input [7:0] idx;
    begin
      reg_addr = {idx, 2'b00};
    end
  endfunction

  wire [1:0] mode   = ctrl_high[`SPU_H_MODE_HI:`SPU_H_MODE_LO];
  wire       sync_m = (mode == `SPU_MODE_SYNC);
  wire       nine_m = mode[1];
  wire [9:0] a      = paddr[`SPU_ADDR_W-1:0];
  wire       acc    = psel && penable && !pready;
  wire       wr     = acc && pwrite;
  wire       hit_h  = (a == reg_addr(`SPU_IDX_CTRL_HIGH));
  wire       hit_l  = (a == reg_addr(`SPU_IDX_CTRL_LOW));
  wire       hit_b  = (a == reg_addr(`SPU_IDX_BAUD));
  wire       hit_d  = (a == reg_addr(`SPU_IDX_DATA));
  wire       mapped = hit_h || hit_l || hit_b || hit_d;
  wire       tx_go  = wr && hit_d;

  // Fixed mode ignores the divisor; others reload from it
  wire [7:0] reload = (mode == `SPU_MODE_ASYNC9F) ? 8'h00 : baud_divisor;
  wire       tick   = (baud_cnt == 8'h00);

  // Parity over data byte replaces software ninth bit when enabled
  wire       ninth_src = ctrl_low[`SPU_L_PARGEN] ? ^pwdata[7:0] : ctrl_high[`SPU_H_TX9];
  wire [3:0] tx_last   = sync_m ? `SPU_SYNC_LAST : (nine_m ? `SPU_D8_LAST : `SPU_SYNC_LAST);
  wire       sync_rx_on = sync_m && ctrl_high[`SPU_H_RXEN] && !ctrl_high[`SPU_H_RXPEND];

  reg set_rxp;
  reg set_txp;
  reg set_rx9;
  reg val_rx9;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cnt <= 8'h00;
    end else if (tick) begin
      baud_cnt <= reload;
    end else begin
      baud_cnt <= baud_cnt - 8'h01;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync1 <= `SPU_IDLE_LINE;
      rx_sync2 <= `SPU_IDLE_LINE;
    end else begin
      rx_sync1 <= rx_pin_in;
      rx_sync2 <= rx_sync1;
    end
  end

  // Transmit and sync shift engine
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state   <= TX_IDLE;
      tx_ovs     <= 4'h0;
      tx_bit     <= 4'h0;
      tx_shift   <= 8'h00;
      tx_ninth   <= 1'b0;
      tx_pin     <= `SPU_IDLE_LINE;
      rx_pin_out <= 1'b0;
      rx_pin_oe  <= 1'b0;
      rx_shift   <= 8'h00;
      rx_state   <= RX_IDLE;
      rx_ovs     <= 4'h0;
      rx_bit     <= 4'h0;
      rx_armed   <= 1'b0;
      set_txp    <= 1'b0;
      set_rxp    <= 1'b0;
      set_rx9    <= 1'b0;
      val_rx9    <= 1'b0;
      rx_buffer  <= 8'h00;
    end else begin
      set_txp <= 1'b0;
      set_rxp <= 1'b0;
      set_rx9 <= 1'b0;
      if (sync_m) begin
        rx_state <= RX_IDLE;
        case (tx_state)
          TX_IDLE: begin
            tx_pin    <= `SPU_IDLE_LINE;
            rx_pin_oe <= 1'b0;
            if (tx_go || (sync_rx_on && !set_rxp)) begin
              tx_shift  <= pwdata[7:0];
              tx_ninth  <= tx_go; // Marks a transmit shift
              tx_bit    <= 4'h0;
              tx_ovs    <= 4'h0;
              tx_state  <= TX_DATA;
              rx_pin_oe <= tx_go;
              rx_pin_out <= pwdata[0];
            end
          end
          TX_DATA: begin
            if (tick) begin
              tx_ovs <= tx_ovs + 4'h1;
              // Clock low first half, high second; data sampled on rise
              tx_pin <= (tx_ovs >= `SPU_OVS_MID) && (tx_ovs != `SPU_OVS_LAST);
              if (tx_ovs == `SPU_OVS_MID && !tx_ninth) begin
                rx_shift <= {rx_sync2, rx_shift[7:1]};
              end
              if (tx_ovs == `SPU_OVS_LAST) begin
                tx_shift   <= {1'b0, tx_shift[7:1]};
                rx_pin_out <= tx_shift[1];
                if (tx_bit == `SPU_SYNC_LAST) begin
                  tx_state <= TX_IDLE;
                  tx_pin   <= `SPU_IDLE_LINE; // No stray clock edge after the last bit
                  rx_pin_oe <= 1'b0;
                  if (tx_ninth) begin
                    set_txp <= 1'b1;
                  end else begin
                    set_rxp   <= 1'b1;
                    rx_buffer <= rx_shift;
                  end
                end
                tx_bit <= tx_bit + 4'h1;
              end
            end
          end
          default: begin
            tx_state <= TX_IDLE;
          end
        endcase
      end else begin
        rx_pin_oe <= 1'b0;
        case (tx_state)
          TX_IDLE: begin
            tx_pin <= `SPU_IDLE_LINE;
            if (tx_go) begin
              tx_shift <= pwdata[7:0];
              tx_ninth <= ninth_src;
              tx_state <= TX_START;
              tx_ovs   <= 4'h0;
              tx_bit   <= 4'h0;
              tx_pin   <= 1'b0;
            end
          end
          TX_START: begin
            if (tick) begin
              tx_ovs <= tx_ovs + 4'h1;
              if (tx_ovs == `SPU_OVS_LAST) begin
                tx_state <= TX_DATA;
                tx_pin   <= tx_shift[0];
              end
            end
          end
          TX_DATA: begin
            if (tick) begin
              tx_ovs <= tx_ovs + 4'h1;
              if (tx_ovs == `SPU_OVS_LAST) begin
                tx_bit <= tx_bit + 4'h1;
                if (tx_bit == tx_last) begin
                  tx_state <= TX_STOP;
                  tx_pin   <= `SPU_IDLE_LINE;
                  set_txp  <= 1'b1;
                end else if (tx_bit == `SPU_SYNC_LAST) begin
                  tx_pin <= tx_ninth;
                end else begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_pin   <= tx_shift[1];
                end
              end
            end
          end
          TX_STOP: begin
            if (tick) begin
              tx_ovs <= tx_ovs + 4'h1;
              if (tx_ovs == `SPU_OVS_LAST) begin
                tx_state <= TX_IDLE;
              end
            end
          end
          default: begin
            tx_state <= TX_IDLE;
          end
        endcase
        // Asynchronous receiver
        case (rx_state)
          RX_IDLE: begin
            // Rearm only after a high line, so a low ninth bit is no start
            if (rx_sync2) begin
              rx_armed <= 1'b1;
            end
            if (ctrl_high[`SPU_H_RXEN] && rx_armed && !rx_sync2 && tick) begin
              rx_state <= RX_START;
              rx_ovs   <= 4'h0;
              rx_armed <= 1'b0;
            end
          end
          RX_START: begin
            if (tick) begin
              rx_ovs <= rx_ovs + 4'h1;
              if (rx_ovs == `SPU_OVS_MID - 4'h1) begin
                // Glitch shorter than half a bit is rejected
                if (rx_sync2) begin
                  rx_state <= RX_IDLE;
                end else begin
                  rx_state <= RX_DATA;
                  rx_bit   <= 4'h0;
                  rx_ovs   <= 4'h0;
                end
              end
            end
          end
          RX_DATA: begin
            if (tick) begin
              rx_ovs <= rx_ovs + 4'h1;
              if (rx_ovs == `SPU_OVS_LAST) begin
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit < `SPU_D8_LAST) begin
                  rx_shift <= {rx_sync2, rx_shift[7:1]};
                end
                // Ninth position: stop bit in 8-bit mode, ninth data bit otherwise
                if (rx_bit == `SPU_D8_LAST) begin
                  rx_state  <= RX_IDLE;
                  set_rxp   <= 1'b1;
                  set_rx9   <= nine_m;
                  val_rx9   <= rx_sync2;
                  rx_buffer <= rx_shift;
                end
              end
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Filter: 9-bit frames with ninth zero raise no pending
  wire rxp_event = set_rxp && !(nine_m && ctrl_high[`SPU_H_MPFILT] && set_rx9 && !val_rx9);

  // Registers; hardware set wins over software clear
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_high    <= `SPU_CTRL_RESET;
      ctrl_low     <= `SPU_CTRL_RESET;
      baud_divisor <= 8'h00;
    end else begin
      if (wr && hit_h) begin
        ctrl_high <= pwdata[7:0];
      end
      if (wr && hit_l) begin
        ctrl_low <= pwdata[7:0];
      end
      if (wr && hit_b) begin
        baud_divisor <= pwdata[7:0];
      end
      if (set_rx9) begin
        ctrl_high[`SPU_H_RX9] <= val_rx9;
      end
      if (rxp_event) begin
        ctrl_high[`SPU_H_RXPEND] <= 1'b1;
      end
      if (set_txp) begin
        ctrl_low[`SPU_L_TXPEND] <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      rx_irq  <= 1'b0;
      tx_irq  <= 1'b0;
      clk_source_sel <= 2'b00;
    end else begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      if (acc && !pwrite) begin
        prdata <= hit_h ? {24'h000000, ctrl_high} :
                  hit_l ? {24'h000000, ctrl_low} :
                  hit_b ? {24'h000000, baud_divisor} :
                  hit_d ? {24'h000000, rx_buffer} : 32'h00000000;
      end
      rx_irq <= ctrl_high[`SPU_H_RXPEND] && ctrl_high[`SPU_H_RXIE];
      tx_irq <= ctrl_low[`SPU_L_TXPEND] && ctrl_low[`SPU_L_TXIE];
      clk_source_sel <= ctrl_low[`SPU_L_CLK_HI:`SPU_L_CLK_LO];
    end
  end

endmodule // spu_serial_port

// ### test/spu_chk_asserts.sv
// Port-level assertions for the serial port block
`timescale 1ns/1ps
module spu_chk (
  input wire        sys_clk,
  input wire        arst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_pin,
  input wire        rx_irq,
  input wire        tx_irq,
  input wire [1:0]  clk_source_sel
);
  wire wr_hi = psel & penable & pwrite & (paddr == 32'h0);
  wire wr_lo = psel & penable & pwrite & (paddr == 32'h4);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_rdy_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready not one wait state");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_unm_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not zero");
  property p_hi_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_tx_idle; $rose(arst_n) |-> tx_pin; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx line not idle high");
  property p_sel_src; $changed(clk_source_sel) |-> $past(wr_lo) || $past(wr_lo, 2); endproperty
  a_sel_src: assert property (p_sel_src) else $error("clock select moved alone");
  property p_tx_keep; $fell(tx_irq) |-> $past(wr_lo) || $past(wr_lo, 2); endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("tx irq dropped alone");
  property p_rx_keep; $fell(rx_irq) |-> $past(wr_hi) || $past(wr_hi, 2); endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx irq dropped alone");
  property p_tx_stop; $rose(tx_irq) && !$past(wr_lo) |-> ##[0:2] tx_pin; endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx irq not at stop bit");
  c_err: cover property (pslverr);
  c_rx: cover property ($rose(rx_irq));
  c_tx: cover property ($rose(tx_irq));
endmodule // spu_chk
bind spu_serial_port spu_chk spu_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_pin(tx_pin), .rx_irq(rx_irq), .tx_irq(tx_irq),
  .clk_source_sel(clk_source_sel));

// ### test/spu_peer.sv
// Remote serial peer: async frames and sync shift partner
`timescale 1ns/1ps
module spu_peer (
  input  wire  sys_clk,
  input  wire  tx_pin,
  input  wire  rx_pin_oe,
  input  wire  rx_pin_out,
  output logic line_drv
);
  // Pull-up level whenever released
  initial line_drv = 1'b1;
  task automatic send(input logic [10:0] frm, input int n, input int cyc);
    for (int i = 0; i < n; i++) begin
      line_drv <= frm[i];
      repeat (cyc) @(posedge sys_clk);
    end
    line_drv <= 1'b1;
    // Let an edge pass so a following frame never drives the line twice at once
    @(posedge sys_clk);
  endtask
  task automatic recv(input int n, input int cyc, output logic [10:0] frm);
    frm = 11'h0;
    @(negedge tx_pin);
    repeat (cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      frm[i] = tx_pin;
      repeat (cyc) @(posedge sys_clk);
    end
  endtask
  task automatic sync_recv(output logic [7:0] d, output int span);
    time t0;
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin);
      d[i] = rx_pin_oe ? rx_pin_out : 1'bx;
      if (i == 0) t0 = $time;
    end
    span = ($time - t0) / 50;
  endtask
  task automatic sync_send(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_pin);
      line_drv <= d[i];
    end
    @(posedge tx_pin);
    // Hold past the mid-bit sample and its input synchroniser
    repeat (8) @(posedge sys_clk);
    line_drv <= 1'b1;
  endtask
endmodule // spu_peer

// ### test/tb_spu_serial_port.sv
// Testbench for the serial port block
`timescale 1ns/1ps
module tb_spu_serial_port;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] r;
  logic        e;
  logic [10:0] f;
  logic [7:0]  sd;
  int          sp;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0;
  wire  [31:0] prdata;
  wire  [1:0]  clk_source_sel;
  wire         pready, pslverr, rx_pin_out, rx_pin_oe, tx_pin, rx_irq, tx_irq, line_drv;
  wire         rx_line = rx_pin_oe ? rx_pin_out : line_drv;
  spu_serial_port spu_serial_port_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin_in(rx_line), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .clk_source_sel(clk_source_sel));
  spu_peer spu_peer_inst (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin_oe(rx_pin_oe),
    .rx_pin_out(rx_pin_out), .line_drv(line_drv));
  always #25 sys_clk = ~sys_clk;
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    apb(1'b1, 32'h8, 32'h5a);
    chk("pslverr", 32'h1, e);
    rd(32'h8, 32'h0);
    chk("pslverr", 32'h1, e);
    apb(1'b1, 32'hc, 32'h1);
    rd(32'hc, 32'h1);
    apb(1'b1, 32'h4, 32'h0e);
    rd(32'h4, 32'h0e);
    chk("clk_source_sel", 32'h3, clk_source_sel);
    apb(1'b1, 32'h0, 32'h40);
    fork spu_peer_inst.recv(10, 32, f); apb(1'b1, 32'h3c0, 32'ha5); join
    chk("frame", {1'b1, 8'ha5, 1'b0}, f);
    chk("tx_irq", 32'h1, tx_irq);
    rd(32'h4, 32'h0f);
    rd(32'h4, 32'h0f);
    apb(1'b1, 32'h4, 32'h8e);
    apb(1'b1, 32'h0, 32'hc0);
    fork spu_peer_inst.recv(11, 32, f); apb(1'b1, 32'h3c0, 32'h07); join
    chk("frame", {2'b11, 8'h07, 1'b0}, f);
    apb(1'b1, 32'h4, 32'h0e);
    apb(1'b1, 32'h0, 32'h88);
    fork spu_peer_inst.recv(11, 16, f); apb(1'b1, 32'h3c0, 32'h5a); join
    chk("frame", {2'b11, 8'h5a, 1'b0}, f);
    apb(1'b1, 32'h0, 32'h52);
    fork
      spu_peer_inst.send({1'b1, 8'h3c, 1'b0}, 10, 32);
      begin
        // After the last data bit, before the stop bit middle
        repeat (290) @(posedge sys_clk);
        chk("rx_irq", 32'h0, rx_irq);
      end
    join
    chk("rx_irq", 32'h1, rx_irq);
    rd(32'h3c0, 32'h3c);
    rd(32'h0, 32'h53);
    apb(1'b1, 32'h0, 32'h51);
    repeat (3) @(posedge sys_clk);
    chk("rx_irq", 32'h0, rx_irq);
    spu_peer_inst.send({1'b1, 8'h11, 1'b0}, 10, 32);
    rd(32'h3c0, 32'h11);
    apb(1'b1, 32'h0, 32'hb2);
    spu_peer_inst.send({2'b10, 8'h81, 1'b0}, 11, 16);
    chk("rx_irq", 32'h0, rx_irq);
    spu_peer_inst.send({2'b11, 8'h42, 1'b0}, 11, 16);
    chk("rx_irq", 32'h1, rx_irq);
    rd(32'h3c0, 32'h42);
    rd(32'h0, 32'hb7);
    apb(1'b1, 32'h0, 32'h00);
    apb(1'b1, 32'h4, 32'h0e);
    fork spu_peer_inst.sync_recv(sd, sp); apb(1'b1, 32'h3c0, 32'h96); join
    chk("sync_tx", 32'h96, sd);
    chk("sync_span", 32'he0, sp);
    repeat (24) @(posedge sys_clk);
    chk("tx_irq", 32'h1, tx_irq);
    fork spu_peer_inst.sync_send(8'hc3); apb(1'b1, 32'h0, 32'h12); join
    while (rx_irq !== 1'b1) @(posedge sys_clk);
    rd(32'h3c0, 32'hc3);
    // Pending set: no further shift may overwrite the byte
    repeat (300) @(posedge sys_clk);
    rd(32'h3c0, 32'hc3);
    conclude();
  end
endmodule // tb_spu_serial_port
